//--- capture_counter_pkg.sv
// Constants shared by the time interval capture counter and its input conditioner.
// Assumes a single system clock; all other inputs are either pins or same-clock logic.
package capture_counter_pkg;
    localparam int         COUNT_WIDTH          = 40;
    localparam int         BYTE_COUNT           = 5;
    localparam logic [4:0] SECOND_SYNTH_DIVIDE  = 5'h14;
    localparam logic [4:0] THIRD_SYNTH_DIVIDE   = 5'h08;
    localparam logic [7:0] PIN_CAPTURE_FUNCTION = 8'h27;
    localparam logic [2:0] LSB_INDEX            = 3'h0;
    localparam logic [2:0] MSB_INDEX            = 3'h4;
    localparam logic       SELECT_THIRD_SYNTH   = 1'b0;
    localparam logic       SELECT_PIN_TRIGGER   = 1'b1;
    localparam logic [COUNT_WIDTH-1:0] COUNT_RESET = 40'h00_0000_0000;
    localparam logic [7:0] BYTE_RESET           = 8'h00;
    localparam logic [4:0] DIVIDER_RESET        = 5'h00;
endpackage

//--- pin_edge_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses.
// Assumes the pin changes slower than a few system clock periods.
`timescale 1ns/1ns
module pin_edge_sync
    import capture_counter_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    input  wire logic pin_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic rise;
        logic fall;
    } sync_state_t;

    sync_state_t st;
    sync_state_t next_st;

    always_comb begin
        next_st      = st;
        next_st.s1   = pin_i;
        next_st.s2   = st.s1;
        next_st.s3   = st.s2;
        next_st.rise = 1'b0;
        next_st.fall = 1'b0;
        // A change counts only once stages two and three agree
        if (st.s2 == st.s3 && st.s3 != st.level) begin
            next_st.level = st.s3;
            next_st.rise  = st.s3;
            next_st.fall  = ~st.s3;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level_o = st.level;
    assign rise_o  = st.rise;
    assign fall_o  = st.fall;
endmodule

//--- time_interval_capture_counter.sv
// Free-running 40-bit time counter with event capture and byte-wise read-back.
// Assumes the serial host logic runs on clk_i and reads bytes with a one-cycle strobe;
// oscillator, chip select and trigger pin arrive asynchronously as pins.
//
// Summary of operation
// - Each accepted trigger latches the whole 40-bit counter into the capture value.
// - While enabled the counter adds one per count tick and wraps to zero.
// - Count tick is second oscillator divided by 20 or third divided by 8.
// - Source select 0 picks third oscillator path, 1 picks second oscillator path.
// - Trigger select 1 uses the trigger pin, 0 uses the chip select.
// - Enable low holds counter at zero; setting it starts counting from zero.
// - An absolute interval runs from enable rising to a later capture.
// - In chip select mode every chip select falling edge captures while enabled and not locked.
// - After the top byte is read in chip select mode, chip select falls are ignored until byte zero read.
// - Pin with function code 0x27 captures on an edge of its chosen polarity.
// - After a pin capture, pin edges are ignored until byte zero is read.
// - Polarity invert chooses rising or falling pin edge as the trigger.
// - Capture value is read back as five separately addressed bytes.
// - Chip select capture happens at the fall, so the same transaction reads it.
// - Source select also picks the oscillator for reference clock checks.
`timescale 1ns/1ns
module time_interval_capture_counter
    import capture_counter_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   sys_rst_i,
    input  wire logic                   second_synthesizer_osc_i,
    input  wire logic                   third_synthesizer_osc_i,
    input  wire logic                   serial_chip_select_n_i,
    input  wire logic                   trigger_pin_i,
    input  wire logic                   time_count_enable_i,
    input  wire logic                   capture_trigger_select_i,
    input  wire logic                   count_source_select_i,
    input  wire logic [7:0]             pin_function_select_i,
    input  wire logic                   pin_polarity_invert_i,
    input  wire logic                   read_strobe_i,
    input  wire logic [2:0]             read_index_i,
    output logic [COUNT_WIDTH-1:0]      time_capture_value_o,
    output logic [7:0]                  read_data_o,
    output logic                        capture_locked_o,
    output logic                        check_osc_level_o
);
    typedef struct packed {
        logic [COUNT_WIDTH-1:0] count;
        logic [COUNT_WIDTH-1:0] capture;
        logic [4:0]             divider;
        logic                   locked;
        logic [7:0]             read_data;
        logic                   check_osc;
    } counter_state_t;

    counter_state_t st;
    counter_state_t next_st;

    logic osc2_level;
    logic osc2_rise;
    logic osc3_level;
    logic osc3_rise;
    logic cs_fall;
    logic pin_rise;
    logic pin_fall;
    logic osc_rise;
    logic [4:0] divide_limit;
    logic count_tick;
    logic pin_mode;
    logic pin_trigger;
    logic cs_trigger;
    logic lsb_read;
    logic msb_read;

    pin_edge_sync u_osc2_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .pin_i     (second_synthesizer_osc_i),
        .level_o   (osc2_level),
        .rise_o    (osc2_rise),
        .fall_o    ()
    );

    pin_edge_sync u_osc3_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .pin_i     (third_synthesizer_osc_i),
        .level_o   (osc3_level),
        .rise_o    (osc3_rise),
        .fall_o    ()
    );

    pin_edge_sync u_cs_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .pin_i     (serial_chip_select_n_i),
        .level_o   (),
        .rise_o    (),
        .fall_o    (cs_fall)
    );

    pin_edge_sync u_pin_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .pin_i     (trigger_pin_i),
        .level_o   (),
        .rise_o    (pin_rise),
        .fall_o    (pin_fall)
    );

    // Byte of the capture value picked by a read index; indices past the top read zero
    function automatic logic [7:0] capture_byte(input logic [COUNT_WIDTH-1:0] value,
                                                input logic [2:0] index);
        logic [7:0] result;
        result = BYTE_RESET;
        for (int i = 0; i < BYTE_COUNT; i++) begin
            if (index == 3'(i)) begin
                result = value[i*8 +: 8];
            end
        end
        return result;
    endfunction

    always_comb begin
        osc_rise     = (count_source_select_i == SELECT_THIRD_SYNTH) ? osc3_rise : osc2_rise;
        divide_limit = (count_source_select_i == SELECT_THIRD_SYNTH) ?
                       THIRD_SYNTH_DIVIDE : SECOND_SYNTH_DIVIDE;
        count_tick   = osc_rise && (st.divider == divide_limit - 5'h01);
        pin_mode     = (capture_trigger_select_i == SELECT_PIN_TRIGGER);
        // Invert chooses the falling edge instead of the rising one
        pin_trigger  = pin_mode && (pin_function_select_i == PIN_CAPTURE_FUNCTION)
                       && (pin_polarity_invert_i ? pin_fall : pin_rise)
                       && !st.locked;
        cs_trigger   = !pin_mode && cs_fall && !st.locked;
        lsb_read     = read_strobe_i && (read_index_i == LSB_INDEX);
        msb_read     = read_strobe_i && (read_index_i == MSB_INDEX);
    end

    always_comb begin
        next_st           = st;
        next_st.check_osc = (count_source_select_i == SELECT_THIRD_SYNTH) ?
                            osc3_level : osc2_level;
        // Divider restarts on any edge past the limit, so a source change settles in one tick
        if (osc_rise) begin
            next_st.divider = count_tick || (st.divider >= divide_limit) ?
                              DIVIDER_RESET : st.divider + 5'h01;
        end
        if (!time_count_enable_i) begin
            next_st.count = COUNT_RESET;
        end else if (count_tick) begin
            next_st.count = st.count + 40'h00_0000_0001;
        end
        if (lsb_read) begin
            next_st.locked = 1'b0;
        end
        if (!pin_mode && msb_read) begin
            next_st.locked = 1'b1;
        end
        // A pin capture beats a same-cycle byte zero read and locks; an edge in the re-arm cycle still sees the old lock and is ignored
        if (time_count_enable_i && (pin_trigger || cs_trigger)) begin
            next_st.capture = st.count;
            if (pin_trigger) begin
                next_st.locked = 1'b1;
            end
        end
        if (read_strobe_i) begin
            next_st.read_data = capture_byte(st.capture, read_index_i);
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign time_capture_value_o = st.capture;
    assign read_data_o          = st.read_data;
    assign capture_locked_o     = st.locked;
    assign check_osc_level_o    = st.check_osc;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence s_msb_read_cs;
        !pin_mode && msb_read && !lsb_read;
    endsequence

    sequence s_held_lock;
        st.locked && !lsb_read;
    endsequence

    property p_hold_zero;
        !time_count_enable_i |=> (st.count == COUNT_RESET);
    endproperty
    a_hold_zero: assert property (p_hold_zero) else $error("counter not held at zero");

    property p_count_step;
        time_count_enable_i && count_tick |=> (st.count == $past(st.count) + 40'h1);
    endproperty
    a_count_step: assert property (p_count_step) else $error("counter did not step");

    property p_count_hold;
        time_count_enable_i && !count_tick |=> $stable(st.count);
    endproperty
    a_count_hold: assert property (p_count_hold) else $error("counter moved without tick");

    property p_divider_range;
        st.divider < SECOND_SYNTH_DIVIDE;
    endproperty
    a_divider_range: assert property (p_divider_range) else $error("divider out of range");

    property p_cs_capture;
        time_count_enable_i && !pin_mode && cs_fall && !st.locked
            |=> (st.capture == $past(st.count));
    endproperty
    a_cs_capture: assert property (p_cs_capture) else $error("chip select fall missed");

    property p_msb_locks;
        s_msb_read_cs |=> st.locked;
    endproperty
    a_msb_locks: assert property (p_msb_locks) else $error("top byte read did not lock");

    property p_lock_freezes;
        s_held_lock |=> $stable(st.capture);
    endproperty
    a_lock_freezes: assert property (p_lock_freezes) else $error("capture moved while locked");

    property p_pin_locks;
        time_count_enable_i && pin_trigger |=> st.locked && (st.capture == $past(st.count));
    endproperty
    a_pin_locks: assert property (p_pin_locks) else $error("pin capture did not lock");

    property p_wrong_function;
        pin_mode && (pin_function_select_i != PIN_CAPTURE_FUNCTION) |=> $stable(st.capture);
    endproperty
    a_wrong_function: assert property (p_wrong_function) else $error("pin captured unselected");

    property p_read_byte;
        read_strobe_i && (read_index_i == MSB_INDEX) |=> (read_data_o == $past(st.capture[39:32]));
    endproperty
    a_read_byte: assert property (p_read_byte) else $error("top byte read wrong");
endmodule

//--- capture_far_side.sv
// Far side model: oscillator pins, serial chip select and trigger pin source.
// Assumes callers step on the falling edge of clk_i; pins park at rest between uses.
`timescale 1ns/1ns
module capture_far_side (
    input  wire logic clk_i,
    output logic      second_osc_o,
    output logic      third_osc_o,
    output logic      chip_select_n_o,
    output logic      trigger_pin_o
);
    logic [1:0] osc;

    assign second_osc_o = osc[1];
    assign third_osc_o  = osc[0];

    initial begin
        osc             = 2'h0;
        chip_select_n_o = 1'b1;
        trigger_pin_o   = 1'b0;
    end

    // Oscillators stand still outside a burst; four cycles a level keep the sync honest
    task automatic osc_edges(input logic second, input int n);
        repeat (n) begin
            repeat (4) @(negedge clk_i);
            osc[second] = 1'b1;
            repeat (4) @(negedge clk_i);
            osc[second] = 1'b0;
        end
        repeat (8) @(negedge clk_i);
    endtask

    task automatic osc_level(input logic second, input logic level);
        @(negedge clk_i);
        osc[second] = level;
        repeat (8) @(negedge clk_i);
    endtask

    // Each level held 12 cycles, well past the quiet and hold times a trigger needs
    task automatic set_pin(input logic level);
        @(negedge clk_i);
        trigger_pin_o = level;
        repeat (12) @(negedge clk_i);
    endtask

    task automatic cs_pulse();
        @(negedge clk_i);
        chip_select_n_o = 1'b0;
        repeat (12) @(negedge clk_i);
        chip_select_n_o = 1'b1;
        repeat (12) @(negedge clk_i);
    endtask
endmodule

//--- time_interval_capture_counter_bench.sv
// Bench for the capture counter: counts are made from whole divider periods of osc edges.
// Assumes the far side model drives all pins and the bench drives the control ports.
`timescale 1ns/1ns
module time_interval_capture_counter_bench
    import capture_counter_pkg::*;
;
    logic                   clk_i;
    logic                   sys_rst_i;
    logic                   second_osc, third_osc, cs_n, pin, locked, osc_lvl;
    logic                   enable, trig_sel, src_sel;
    logic                   invert, strobe;
    logic [7:0]             func;
    logic [2:0]             index;
    logic [7:0]             rdata;
    logic [COUNT_WIDTH-1:0] capture;
    int                     fail_count = 0, checked = 0, cycles = 0;

    always #50 clk_i = ~clk_i;

    capture_far_side capture_far_side_i (.clk_i(clk_i), .second_osc_o(second_osc),
        .third_osc_o(third_osc), .chip_select_n_o(cs_n), .trigger_pin_o(pin));

    time_interval_capture_counter time_interval_capture_counter_i (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .second_synthesizer_osc_i(second_osc),
        .third_synthesizer_osc_i(third_osc), .serial_chip_select_n_i(cs_n),
        .trigger_pin_i(pin), .time_count_enable_i(enable),
        .capture_trigger_select_i(trig_sel), .count_source_select_i(src_sel),
        .pin_function_select_i(func), .pin_polarity_invert_i(invert),
        .read_strobe_i(strobe), .read_index_i(index), .time_capture_value_o(capture),
        .read_data_o(rdata), .capture_locked_o(locked), .check_osc_level_o(osc_lvl));

    task automatic check(input logic [COUNT_WIDTH-1:0] seen, input logic [COUNT_WIDTH-1:0] want);
        checked++;
        if (seen !== want) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic read_byte(input logic [2:0] idx);
        @(negedge clk_i);
        strobe = 1'b1;
        index  = idx;
        @(negedge clk_i);
        strobe = 1'b0;
    endtask

    task automatic summarize();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Whole run needs about 1400 cycles
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            summarize();
        end
    end

    initial begin
        clk_i     = 1'b0;
        sys_rst_i = 1'b1;
        enable    = 1'b0;
        trig_sel  = 1'b0;
        src_sel   = 1'b0;
        invert    = 1'b0;
        strobe    = 1'b0;
        func      = 8'h27;
        index     = 3'h0;
        repeat (2) @(negedge clk_i);
        sys_rst_i = 1'b0;
        check(capture, 40'h0);
        check(locked, 1'b0);
        enable = 1'b1;
        capture_far_side_i.osc_edges(1'b0, 24);
        capture_far_side_i.cs_pulse();
        check(capture, 40'h3);
        read_byte(3'h4);
        check(rdata, 8'h00);
        check(locked, 1'b1);
        capture_far_side_i.osc_edges(1'b0, 16);
        capture_far_side_i.cs_pulse();
        check(capture, 40'h3);
        read_byte(3'h0);
        check(rdata, 8'h03);
        check(locked, 1'b0);
        capture_far_side_i.cs_pulse();
        check(capture, 40'h5);
        read_byte(3'h5);
        check(rdata, 8'h00);
        src_sel = 1'b1;
        capture_far_side_i.osc_edges(1'b1, 40);
        capture_far_side_i.osc_edges(1'b0, 8);
        capture_far_side_i.cs_pulse();
        check(capture, 40'h7);
        src_sel  = 1'b0;
        trig_sel = 1'b1;
        capture_far_side_i.osc_edges(1'b0, 8);
        capture_far_side_i.cs_pulse();
        check(capture, 40'h7);
        capture_far_side_i.set_pin(1'b1);
        check(capture, 40'h8);
        check(locked, 1'b1);
        capture_far_side_i.osc_edges(1'b0, 8);
        capture_far_side_i.set_pin(1'b0);
        capture_far_side_i.set_pin(1'b1);
        check(capture, 40'h8);
        read_byte(3'h0);
        check(rdata, 8'h08);
        check(locked, 1'b0);
        capture_far_side_i.set_pin(1'b0);
        check(capture, 40'h8);
        capture_far_side_i.set_pin(1'b1);
        check(capture, 40'h9);
        read_byte(3'h0);
        invert = 1'b1;
        capture_far_side_i.osc_edges(1'b0, 8);
        capture_far_side_i.set_pin(1'b0);
        check(capture, 40'hA);
        read_byte(3'h0);
        func = 8'h26;
        capture_far_side_i.osc_edges(1'b0, 8);
        capture_far_side_i.set_pin(1'b1);
        capture_far_side_i.set_pin(1'b0);
        check(capture, 40'hA);
        // Toggling enable clears the count before a known start
        enable = 1'b0;
        repeat (4) @(negedge clk_i);
        enable   = 1'b1;
        trig_sel = 1'b0;
        capture_far_side_i.cs_pulse();
        check(capture, 40'h0);
        capture_far_side_i.osc_edges(1'b0, 8);
        capture_far_side_i.cs_pulse();
        check(capture, 40'h1);
        src_sel = 1'b1;
        capture_far_side_i.osc_level(1'b0, 1'b1);
        check(osc_lvl, 1'b0);
        src_sel = 1'b0;
        repeat (8) @(negedge clk_i);
        check(osc_lvl, 1'b1);
        summarize();
    end
endmodule
